/* dv/board_io_glue_bench.sv */
// Directed bench for the board I/O glue.
module board_io_glue_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, io_rd = 1'b0, io_wr = 1'b0;
  logic [15:0] io_addr = 16'h0000;
  logic [7:0] io_wdata = 8'h00, board_revision = 8'h10, io_rdata_q;
  logic [1:0] timer_in = 2'h1, timer_gp_q;
  logic [3:0] usb_irq_line_q, serial_enable_q;
  logic board_reboot_q, programmable_led_output_oe_q, programmable_led_output_q, usb_irq_q;
  logic third_rts_q, third_tx_en_q, fourth_rts_q, fourth_tx_en_q;
  logic first_usb_fault_n, second_usb_fault_n, pushbutton_reboot_input_n;
  int fails = 0, comparisons = 0, cyc = 0;
  board_io_glue u_dut (.*);
  board_switch_model u_sw (.*);
  initial forever #5 clk = ~clk;
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // The ceiling sits well above the roughly 140 cycles the tests need.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      fails++;
      conclude();
    end
  end
  task automatic check(input string nm, input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk) {io_addr, io_wdata, io_wr} = {a, d, 1'b1};
    @(negedge clk) io_wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge clk) {io_addr, io_rd} = {a, 1'b1};
    @(negedge clk) io_rd = 1'b0;
    d = io_rdata_q;
  endtask
  task automatic rdchk(input string nm, input logic [15:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    check(nm, d, e);
  endtask
  initial
  begin
    logic [7:0] v;
    ticks(12);
    rst = 1'b0;
    ticks(3);
    rdchk("led port", 16'h01E0, 8'h2A);
    check("led oe", programmable_led_output_oe_q, 8'h00);
    check("led pin", programmable_led_output_q, 8'h00);
    rdchk("mcr3", 16'h03EC, 8'h02);
    rdchk("unmapped", 16'h0300, 8'h00);
    rdchk("revision", 16'h01E1, 8'h10);
    $display("reset test done");
    rd(16'h01E0, v);
    wr(16'h01E0, v | 8'h80);
    ticks(2);
    check("led on", programmable_led_output_oe_q, 8'h01);
    rdchk("led port", 16'h01E0, 8'hAA);
    wr(16'h01E0, 8'h7F);
    ticks(2);
    check("led off", programmable_led_output_oe_q, 8'h00);
    rdchk("led port", 16'h01E0, 8'h2A);
    $display("led test done");
    for (int m = 0; m < 3; m++)
      for (int b = 0; b < 2; b++)
      begin
        wr(16'h01E3, 8'(m * 5));
        wr(16'h03EC, 8'(b * 2));
        wr(16'h02E8, 8'(b * 2));
        ticks(3);
        check("rts3", third_rts_q, 8'(b == 0));
        check("tx3", third_tx_en_q, 8'(m != 2 || b == 0));
        check("rts4", fourth_rts_q, 8'(b == 0));
        check("tx4", fourth_tx_en_q, 8'(m != 2 || b == 0));
      end
    wr(16'h03EC, 8'h00);
    wr(16'h02E8, 8'h00);
    wr(16'h01E6, 8'h0B);
    ticks(3);
    check("enables", serial_enable_q, 8'h0B);
    check("rts3 off", third_rts_q, 8'h00);
    check("rts4 on", fourth_rts_q, 8'h01);
    $display("serial test done");
    u_sw.set(3'b011);
    ticks(3);
    rd(16'h01E4, v);
    check("gpio0", v & 8'h03, 8'h02);
    wr(16'h01E5, 8'h8A);
    ticks(2);
    check("irq", usb_irq_q, 8'h01);
    check("irq line", usb_irq_line_q, 8'h0A);
    wr(16'h01E5, 8'h0A);
    ticks(2);
    check("irq off", usb_irq_q, 8'h00);
    u_sw.set(3'b111);
    ticks(3);
    rd(16'h01E4, v);
    check("gpio0", v & 8'h03, 8'h03);
    check("timers", timer_gp_q, 8'h02);
    wr(16'h01E0, 8'h80);
    board_revision = 8'h20;
    rst = 1'b1;
    ticks(2);
    rst = 1'b0;
    ticks(3);
    check("led reset", programmable_led_output_oe_q, 8'h00);
    rdchk("revision", 16'h01E1, 8'h20);
    check("timers", timer_gp_q, 8'h01);
    u_sw.set(3'b110);
    ticks(1);
    u_sw.set(3'b111);
    ticks(1);
    check("reboot", board_reboot_q, 8'h01);
    ticks(10);
    check("reboot held", board_reboot_q, 8'h01);
    ticks(1);
    check("reboot end", board_reboot_q, 8'h00);
    $display("status test done");
    conclude();
  end
endmodule // board_io_glue_bench

/* dv/board_io_glue_properties.sv */
// Port-level concurrent checks of the board I/O glue.
module board_io_glue_properties (
  input logic        clk,
  input logic        rst,
  input logic [15:0] io_addr,
  input logic        io_rd,
  input logic        io_wr,
  input logic [7:0]  io_wdata,
  input logic [7:0]  io_rdata_q,
  input logic        pushbutton_reboot_input_n,
  input logic        board_reboot_q,
  input logic        programmable_led_output_oe_q,
  input logic        programmable_led_output_q,
  input logic        third_rts_q,
  input logic        third_tx_en_q,
  input logic        first_usb_fault_n,
  input logic        second_usb_fault_n,
  input logic        usb_irq_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_led_pin_low: assert property (!programmable_led_output_q)
    else $error("led pin data not low");
  a_led_code_read: assert property ($past(io_rd) && $past(io_addr) == 16'h01E0
    |-> io_rdata_q[6:0] == 7'h2A) else $error("product code wrong");
  a_led_write_bit: assert property (io_wr && io_addr == 16'h01E0
    |-> ##2 programmable_led_output_oe_q == ($past(io_wdata, 2) > 8'h7F)) else $error("led bit");
  a_gpio_fault_read: assert property ($past(io_rd) && $past(io_addr) == 16'h01E4 |->
    io_rdata_q[0] == $past(first_usb_fault_n) && io_rdata_q[1] == $past(second_usb_fault_n))
    else $error("fault status read wrong");
  a_rts_gates_driver: assert property (third_rts_q |-> third_tx_en_q)
    else $error("rts high with driver off");
  a_rts_clear_write: assert property (io_wr && io_addr == 16'h03EC && io_wdata[1]
    |-> ##3 !third_rts_q) else $error("rts still high");
  a_reboot_on_button: assert property (!pushbutton_reboot_input_n |-> ##[1:2] board_reboot_q)
    else $error("no reboot");
  a_reboot_holds: assert property ($rose(board_reboot_q) |-> board_reboot_q[*8])
    else $error("reboot pulse short");
  a_irq_quiet_healthy: assert property ((first_usb_fault_n && second_usb_fault_n)[*3]
    |-> !usb_irq_q) else $error("irq without fault");
endmodule // board_io_glue_properties

bind board_io_glue board_io_glue_properties u_props (.*);

/* dv/board_switch_model.sv */
// Far-side model: USB power switch status outputs and the reboot push-button.
module board_switch_model (
  output logic first_usb_fault_n,
  output logic second_usb_fault_n,
  output logic pushbutton_reboot_input_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // Both status lines are low-true, so a healthy switch holds them high.
  initial {first_usb_fault_n, second_usb_fault_n, pushbutton_reboot_input_n} = 3'h7;
  task automatic set(input logic [2:0] v);
    {first_usb_fault_n, second_usb_fault_n, pushbutton_reboot_input_n} = v;
  endtask
endmodule // board_switch_model

/* logic/board_io_glue.v */
// Board I/O glue top: LED port, serial channel line control, USB fault status, reboot.
// ==========================================================================
// Overview of operation
// - RS-485 mode gates the channel's transmit driver from its request-to-send output.
// - Clearing modem control bit 1 drives request-to-send high and enables driver.
// - Setting modem control bit 1 drives request-to-send low, disabling the driver in RS-485 mode only.
// - Third and fourth channels select RS-232, RS-422 or RS-485 operation.
// - First and second channels are RS-232 only, no mode selection.
// - Serial interrupts may share lines only with other serial interrupts.
// - Each serial channel is enabled and addressed independently.
// - LED port bit 7 written one lights the LED, zero turns it off.
// - Pulling the push-button input low reboots the board.
// - USB power switch faults are active low status inputs.
// - First USB fault reads at general port bit 0, second at bit 1.
// - General port zero interrupts can be enabled and routed to a selected line.
// - Board revision 1.00 and earlier swaps general timer inputs 0 and 1.
// - LED port bits 6 to 0 read a fixed product code and ignore writes.
`include "board_io_regs.vh"
module board_io_glue (
  input  wire        clk,
  input  wire        rst,
  input  wire [15:0] io_addr,
  input  wire        io_rd,
  input  wire        io_wr,
  input  wire [7:0]  io_wdata,
  output reg  [7:0]  io_rdata_q,
  input  wire        pushbutton_reboot_input_n,
  output reg         board_reboot_q,
  output reg         programmable_led_output_oe_q,
  output reg         programmable_led_output_q,
  output reg         third_rts_q,
  output reg         third_tx_en_q,
  output reg         fourth_rts_q,
  output reg         fourth_tx_en_q,
  input  wire        first_usb_fault_n,
  input  wire        second_usb_fault_n,
  output reg         usb_irq_q,
  output reg  [3:0]  usb_irq_line_q,
  output reg  [3:0]  serial_enable_q,
  input  wire [1:0]  timer_in,
  output reg  [1:0]  timer_gp_q,
  input  wire [7:0]  board_revision
);
  // Product code value is arbitrary.
  localparam [6:0] PRODUCT = `PRODUCT_CODE;
  reg        led_q;
  reg  [7:0] mcr3_q;
  reg  [7:0] mcr4_q;
  reg  [3:0] mode_q;
  reg  [7:0] irq_q;
  reg  [3:0] cfg_q;
  reg  [7:0] rev_q;
  reg        rev_seen_q;
  reg        swap_q;
  reg  [7:0] rd_d;
  wire [1:0] faults   = {~second_usb_fault_n, ~first_usb_fault_n};
  wire [1:0] rts_bits = {mcr4_q[`RTS_BIT], mcr3_q[`RTS_BIT]};
  wire [1:0] chan_on  = cfg_q[3:2];
  wire [1:0] rts_ch;
  wire [1:0] en_ch;
  wire       reboot;
  // ==========================================================================
  // Address decode
  // Full 16-bit compare, so no alias of these ports elsewhere in I/O space is claimed.
  wire       hit_led  = (io_addr == `LED_PORT_ADDR);
  wire       hit_mcr3 = (io_addr == `MCR3_ADDR);
  wire       hit_mcr4 = (io_addr == `MCR4_ADDR);
  wire       hit_mode = (io_addr == `MODE_ADDR);
  wire       hit_irq  = (io_addr == `GPIO0_IRQ_ADDR);
  wire       hit_cfg  = (io_addr == `COM_CFG_ADDR);
  // ==========================================================================
  // Read values
  wire [7:0] led_rd   = {led_q, PRODUCT};
  wire [7:0] mode_rd  = {4'h0, mode_q};
  wire [7:0] gpio0_rd = {6'h00, ~faults};
  wire [7:0] cfg_rd   = {4'h0, cfg_q};
  // ==========================================================================
  // LED bit; the product code below it has no storage, so writes to it vanish.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      led_q <= 1'b0;
    end
    else if (io_wr && hit_led)
    begin
      led_q <= io_wdata[`LED_BIT];
    end
  end
  // ==========================================================================
  // Third channel modem control; reset leaves bit 1 set, so request-to-send starts low.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mcr3_q <= `MCR_RESET;
    end
    else if (io_wr && hit_mcr3)
    begin
      mcr3_q <= io_wdata;
    end
  end
  // ==========================================================================
  // Fourth channel modem control
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mcr4_q <= `MCR_RESET;
    end
    else if (io_wr && hit_mcr4)
    begin
      mcr4_q <= io_wdata;
    end
  end
  // ==========================================================================
  // Line modes of the third and fourth channels; the first two have no mode at all.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mode_q <= 4'h0;
    end
    else if (io_wr && hit_mode)
    begin
      mode_q <= io_wdata[3:0];
    end
  end
  // ==========================================================================
  // General port zero interrupt control
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      irq_q <= `ZERO8;
    end
    else if (io_wr && hit_irq)
    begin
      irq_q <= io_wdata;
    end
  end
  // ==========================================================================
  // Channel enables
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cfg_q <= 4'hF;
    end
    else if (io_wr && hit_cfg)
    begin
      cfg_q <= io_wdata[3:0];
    end
  end
  // ==========================================================================
  // Revision capture after reset release; straps must not feed the async reset.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rev_q      <= `ZERO8;
      rev_seen_q <= 1'b0;
      swap_q     <= 1'b0;
    end
    else if (!rev_seen_q)
    begin
      rev_q      <= board_revision;
      rev_seen_q <= 1'b1;
      swap_q     <= (board_revision <= `REV_SWAP_LIMIT);
    end
  end
  // ==========================================================================
  // Read mux
  always @*
  begin
    rd_d = `ZERO8;
    case (io_addr)
      `LED_PORT_ADDR:  rd_d = led_rd;
      `MCR3_ADDR:      rd_d = mcr3_q;
      `MCR4_ADDR:      rd_d = mcr4_q;
      `MODE_ADDR:      rd_d = mode_rd;
      `GPIO0_ADDR:     rd_d = gpio0_rd;
      `GPIO0_IRQ_ADDR: rd_d = irq_q;
      `COM_CFG_ADDR:   rd_d = cfg_rd;
      `REV_ADDR:       rd_d = rev_q;
      default:         rd_d = `ZERO8;
    endcase
  end
  // ==========================================================================
  // Serial line control, one controller per multi-mode channel
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1)
    begin : g_line
      line_driver_ctl u_line (
        .clk           (clk),
        .rst           (rst),
        .mode          (mode_q[2*ch +: 2]),
        .rts_bit       (rts_bits[ch]),
        .rts_out_q     (rts_ch[ch]),
        .tx_drive_en_q (en_ch[ch])
      );
    end
  endgenerate
  // ==========================================================================
  // Push-button reboot
  reset_stretch u_reboot (
    .clk        (clk),
    .rst        (rst),
    .button_low (~pushbutton_reboot_input_n),
    .reboot_q   (reboot)
  );
  // ==========================================================================
  // Read data stands one cycle per read strobe and is zero otherwise.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      io_rdata_q <= `ZERO8;
    end
    else
    begin
      io_rdata_q <= io_rd ? rd_d : `ZERO8;
    end
  end
  // ==========================================================================
  // Board reboot output
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      board_reboot_q <= 1'b0;
    end
    else
    begin
      board_reboot_q <= reboot;
    end
  end
  // ==========================================================================
  // LED pin is open drain: the data stays low and the enable sinks the current.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      programmable_led_output_oe_q <= 1'b0;
      programmable_led_output_q    <= 1'b0;
    end
    else
    begin
      programmable_led_output_oe_q <= led_q;
      programmable_led_output_q    <= 1'b0;
    end
  end
  // ==========================================================================
  // Serial outputs; a disabled channel keeps its handshake and driver quiet.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      third_rts_q     <= 1'b0;
      third_tx_en_q   <= 1'b0;
      fourth_rts_q    <= 1'b0;
      fourth_tx_en_q  <= 1'b0;
      serial_enable_q <= 4'h0;
    end
    else
    begin
      third_rts_q     <= rts_ch[0] & chan_on[0];
      third_tx_en_q   <= en_ch[0] & chan_on[0];
      fourth_rts_q    <= rts_ch[1] & chan_on[1];
      fourth_tx_en_q  <= en_ch[1] & chan_on[1];
      serial_enable_q <= cfg_q;
    end
  end
  // ==========================================================================
  // USB fault interrupt
  // The interrupt routes to one selected line only; sharing is left to software setup.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      usb_irq_q      <= 1'b0;
      usb_irq_line_q <= 4'h0;
    end
    else
    begin
      usb_irq_q      <= irq_q[7] & (|faults);
      usb_irq_line_q <= irq_q[3:0];
    end
  end
  // ==========================================================================
  // General timer inputs
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      timer_gp_q <= 2'h0;
    end
    else if (swap_q)
    begin
      timer_gp_q <= {timer_in[0], timer_in[1]};
    end
    else
    begin
      timer_gp_q <= timer_in;
    end
  end
endmodule // board_io_glue

/* logic/board_io_regs.vh */
// Constants for the board I/O glue: register offsets, fields, reset values and timing counts.
`ifndef BOARD_IO_REGS_VH
`define BOARD_IO_REGS_VH
// ==========================================================================
// Register offsets
`define LED_PORT_ADDR      16'h01E0
`define MCR3_ADDR          16'h03EC
`define MCR4_ADDR          16'h02E8
`define MODE_ADDR          16'h01E3
`define GPIO0_ADDR         16'h01E4
`define GPIO0_IRQ_ADDR     16'h01E5
`define COM_CFG_ADDR       16'h01E6
`define REV_ADDR           16'h01E1
// ==========================================================================
// Fields
`define LED_BIT            7
`define RTS_BIT            1
`define PRODUCT_CODE       7'h2A
`define MCR_RESET          8'h02
`define MODE_232           2'h0
`define MODE_422           2'h1
`define MODE_485           2'h2
`define REV_SWAP_LIMIT     8'h10
`define ZERO8              8'h00
// ==========================================================================
// Timing
`define RESET_HOLD_NS      100
`define CLK_PERIOD_NS      10
`define RESET_HOLD_CYC     ((`RESET_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* logic/line_driver_ctl.v */
// Per-channel RS-232/422/485 line control for the third and fourth serial channels.
`include "board_io_regs.vh"
module line_driver_ctl (
  input  wire       clk,
  input  wire       rst,
  input  wire [1:0] mode,
  input  wire       rts_bit,
  output reg        rts_out_q,
  output reg        tx_drive_en_q
);
  // ==========================================================================
  // Driver gating
  // A set modem bit drives the handshake low; in RS-485 the handshake gates the driver.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rts_out_q     <= 1'b0;
      tx_drive_en_q <= 1'b0;
    end
    else
    begin
      rts_out_q <= ~rts_bit;
      case (mode)
        `MODE_485: tx_drive_en_q <= ~rts_bit;
        `MODE_422: tx_drive_en_q <= 1'b1;
        default:   tx_drive_en_q <= 1'b1;
      endcase
    end
  end
endmodule // line_driver_ctl

/* logic/reset_stretch.v */
// Stretches the synchronous push-button reboot request into a board reset pulse.
`include "board_io_regs.vh"
module reset_stretch (
  input  wire clk,
  input  wire rst,
  input  wire button_low,
  output reg  reboot_q
);
  localparam integer HOLD_CYC = `RESET_HOLD_CYC;
  localparam [7:0]   HOLD     = HOLD_CYC[7:0];
  reg [7:0] cnt_q;
  // ==========================================================================
  // Hold counter
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q    <= 8'h00;
      reboot_q <= 1'b0;
    end
    else if (button_low)
    begin
      cnt_q    <= HOLD;
      reboot_q <= 1'b1;
    end
    else if (cnt_q != 8'h00)
    begin
      cnt_q    <= cnt_q - 8'h01;
      reboot_q <= 1'b1;
    end
    else
      reboot_q <= 1'b0;
  end
endmodule // reset_stretch
